/* File: bench/analog_front_model.sv */
// behavioural analog front end: sampling array and ideal comparator
`timescale 1ns/1ns
module analog_front_model (
   // clock
   input wire logic core_clk,
   // input level as an ideal code
   input wire logic [15:0] vin,
   // switch controls from the block
   input wire logic input_connect,
   input wire logic [15:0] array_switches,
   // comparator decision
   output logic comparator_high
);
   logic [15:0] held; // charge left on the array after disconnect

   // track while connected, hold once the block lets go
   always_ff @(posedge core_clk) begin
      if (input_connect) begin
         held <= vin;
      end
   end

   // keep the trial bit while the held level reaches the trial weight
   assign comparator_high = (held >= array_switches);
endmodule

/* File: bench/tb.sv */
// self-checking bench for the conversion control
`timescale 1ns/1ns
module tb;
   import sar_conversion_pkg::*;

   localparam int BUSY_LEN = 2 + 16 * 4 + 1; // open, connect, trials, finish
   logic core_clk, resetn, hsel, hwrite, hready, hreadyout, hresp; // clock, reset, bus strobes
   logic [7:0] haddr; // bus address
   logic [1:0] htrans; // bus transfer kind
   logic [2:0] hsize; // bus size
   logic [31:0] hwdata, hrdata; // bus data
   logic convert_start_n, coding_select, fastest_rate_select, pulsed_power_select, busy; // pins
   logic comparator_high, over_range, under_range, power_save; // front end
   logic array_ground_switch, dummy_ground_switch, input_connect, reference_ground_connect; // switches
   logic [15:0] result_code, array_switches, vin; // codes
   int errors, num_checks; // counters

   // clock generator
   initial begin
      core_clk = 1'b0;
      forever #(CLK_NS / 2) core_clk = ~core_clk;
   end

   // single slave drives the bus ready
   assign hready = hreadyout;

   // block under test, short accuracy gap
   sar_conversion_control #(.GAP_CYCLES(1000), .GAP_W(18), .STEP_CYCLES(4)) u_dut (
      .core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .convert_start_n(convert_start_n), .coding_select(coding_select),
      .fastest_rate_select(fastest_rate_select), .pulsed_power_select(pulsed_power_select),
      .busy(busy), .result_code(result_code), .comparator_high(comparator_high),
      .over_range(over_range), .under_range(under_range), .array_ground_switch(array_ground_switch),
      .dummy_ground_switch(dummy_ground_switch), .input_connect(input_connect),
      .reference_ground_connect(reference_ground_connect), .array_switches(array_switches),
      .power_save(power_save));

   // analog side
   analog_front_model u_front (.core_clk(core_clk), .vin(vin), .input_connect(input_connect),
      .array_switches(array_switches), .comparator_high(comparator_high));

   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // closing verdict
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // one single word transfer, address phase then data phase
   task automatic ahb_xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'b010;
      do @(posedge core_clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge core_clk); while (hready !== 1'b1);
      rd = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask

   // pin-started conversion, checks switch order, busy span and code
   task automatic convert(input logic [15:0] v, input logic cs, ov, un, input logic [15:0] exp);
      int n;
      @(posedge core_clk);
      vin <= v;
      coding_select <= cs;
      over_range <= ov;
      under_range <= un;
      repeat (3) @(posedge core_clk); // synchronisers settle
      convert_start_n <= 1'b0;
      @(posedge core_clk);
      convert_start_n <= 1'b1;
      n = 0;
      do begin @(negedge core_clk); n++; end while (busy !== 1'b1 && n < 1200);
      // grounds open first, input still connected
      check({array_ground_switch, dummy_ground_switch, input_connect, reference_ground_connect}, 4'b0010);
      @(negedge core_clk);
      check({array_ground_switch, dummy_ground_switch, input_connect, reference_ground_connect}, 4'b0001);
      @(negedge core_clk);
      check(array_switches, 16'h8000);
      n = 3;
      do begin @(negedge core_clk); n++; end while (busy === 1'b1 && n < 300);
      check(n - 1, BUSY_LEN);
      check(result_code, exp);
   endtask

   // wait for the next busy rise, counting cycles; power_save seen high at any idle cycle
   // power_save drops in the start cycle itself, so the last idle cycle alone tells nothing
   task automatic wait_rise(output int n, output logic ps_seen);
      n = 0;
      ps_seen = 1'b0;
      while (busy === 1'b1 && n < 2000) begin
         @(negedge core_clk);
         n++;
      end
      while (busy !== 1'b1 && n < 2000) begin
         @(negedge core_clk);
         n++;
         if (busy !== 1'b1) begin
            ps_seen = ps_seen | power_save;
         end
      end
   endtask

   // start held low: conversions repeat at the mode's spacing
   task automatic mode_spacing(input logic f, p, input int ksps, input logic ps);
      int n, per;
      logic ps_seen;
      per = (NS_PER_MS + ksps * CLK_NS - 1) / (ksps * CLK_NS);
      @(posedge core_clk);
      fastest_rate_select <= f;
      pulsed_power_select <= p;
      repeat (3) @(posedge core_clk);
      convert_start_n <= 1'b0;
      wait_rise(n, ps_seen);
      wait_rise(n, ps_seen);
      check(32'(n >= per && n <= per + 1), 32'h1);
      check(ps_seen, ps);
      @(posedge core_clk);
      convert_start_n <= 1'b1;
      wait_rise(n, ps_seen);
   endtask

   // software start, status flags, result register, unmapped space
   task automatic register_start();
      logic [31:0] rd;
      int n;
      ahb_xfer(REG_CTRL, 1'b0, 32'h0, rd);
      check(rd, 32'h0);
      ahb_xfer(8'h0c, 1'b1, 32'hffff_ffff, rd); // unmapped write, ignored
      ahb_xfer(8'h0c, 1'b0, 32'h0, rd);
      check(rd, 32'h0);
      ahb_xfer(REG_CTRL, 1'b1, 32'h1, rd);
      n = 0;
      do begin @(negedge core_clk); n++; end while (busy !== 1'b1 && n < 20);
      do begin @(negedge core_clk); n++; end while (busy === 1'b1 && n < 200);
      check(busy, 1'b0);
      ahb_xfer(REG_STATUS, 1'b0, 32'h0, rd);
      check(rd, 32'h6);
      ahb_xfer(REG_RESULT, 1'b0, 32'h0, rd);
      check(rd, 32'h5a5a);
      ahb_xfer(REG_STATUS, 1'b0, 32'h0, rd);
      check(rd, 32'h2);
      convert(16'h4321, 1'b1, 1'b0, 1'b0, 16'h4321);
      ahb_xfer(REG_STATUS, 1'b0, 32'h0, rd);
      check(rd, 32'h4);
   endtask

   // main sequence
   initial begin
      errors = 0;
      num_checks = 0;
      resetn = 1'b0;
      {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
      {convert_start_n, coding_select, fastest_rate_select, pulsed_power_select} = 4'b1110;
      {over_range, under_range} = 2'b00;
      vin = 16'h5a5a;
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      @(negedge core_clk);
      check({busy, result_code, array_ground_switch, input_connect, reference_ground_connect}, 20'h00006);
      check(hrdata, 32'h0);
      check(32'(array_switches), 32'h0);
      register_start();
      convert(16'hffff, 1'b1, 1'b0, 1'b0, 16'hffff);
      convert(16'h8000, 1'b1, 1'b0, 1'b0, 16'h8000);
      convert(16'h0000, 1'b1, 1'b0, 1'b0, 16'h0000);
      convert(16'hffff, 1'b0, 1'b0, 1'b0, 16'h7fff);
      convert(16'h8000, 1'b0, 1'b0, 1'b0, 16'h0000);
      convert(16'h0000, 1'b0, 1'b0, 1'b0, 16'h8000);
      convert(16'h1234, 1'b1, 1'b0, 1'b0, 16'h1234);
      convert(16'h1234, 1'b0, 1'b0, 1'b0, 16'h9234);
      convert(16'h0000, 1'b1, 1'b1, 1'b0, 16'hffff);
      convert(16'h0000, 1'b0, 1'b1, 1'b0, 16'h7fff);
      convert(16'hffff, 1'b1, 1'b0, 1'b1, 16'h0000);
      convert(16'hffff, 1'b0, 1'b0, 1'b1, 16'h8000);
      mode_spacing(1'b1, 1'b0, FAST_KSPS, 1'b0);
      mode_spacing(1'b0, 1'b0, NORMAL_KSPS, 1'b0);
      mode_spacing(1'b0, 1'b1, PULSED_KSPS, 1'b1);
      mode_spacing(1'b1, 1'b1, FAST_KSPS, 1'b0);
      give_verdict();
   end

   // watchdog: runs well past the expected length
   initial begin
      repeat (60000) @(posedge core_clk);
      errors++;
      give_verdict();
   end
endmodule

/* File: hdl/sar_conversion_control.sv */
// successive-approximation conversion control with ahb-lite status and result registers
`timescale 1ns/1ns
module sar_conversion_control #(
   parameter int GAP_CYCLES = sar_conversion_pkg::GAP_CYCLES_DEF, // fastest-mode gap in cycles
   parameter int GAP_W = 18, // gap counter width
   parameter int STEP_CYCLES = 4 // settling per trial, covers comparator sync
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // conversion pins
   input wire logic convert_start_n,
   input wire logic coding_select,
   input wire logic fastest_rate_select,
   input wire logic pulsed_power_select,
   output logic busy,
   output logic [sar_conversion_pkg::CODE_W-1:0] result_code,
   // analog front end
   input wire logic comparator_high,
   input wire logic over_range,
   input wire logic under_range,
   output logic array_ground_switch,
   output logic dummy_ground_switch,
   output logic input_connect,
   output logic reference_ground_connect,
   output logic [sar_conversion_pkg::CODE_W-1:0] array_switches,
   output logic power_save
);
   import sar_conversion_pkg::*;

   localparam int STEP_W = 8;
   localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);
   localparam logic [GAP_W-1:0] GAP_LIMIT = GAP_W'(GAP_CYCLES);
   localparam int CONV_BOUND = 400; // above any conversion length with sane settling
   localparam int START_BOUND = 600; // longest mode spacing plus sync margin, a held edge may wait this long

   // weight of one trial element
   function automatic logic [CODE_W-1:0] trial_bit(input logic [BIT_IDX_W-1:0] idx);
      trial_bit = CODE_ONE << idx;
   endfunction

   // least start spacing for the selected mode
   function automatic logic [PERIOD_W-1:0] period_for(input logic fast, input logic pulsed);
      if (fast) begin
         period_for = FAST_PERIOD;
      end else if (pulsed) begin
         period_for = PULSED_PERIOD;
      end else begin
         period_for = NORMAL_PERIOD;
      end
   endfunction

   // output code from the resolved value and range flags
   function automatic logic [CODE_W-1:0] format_code(input logic [CODE_W-1:0] raw, input logic over,
                                                      input logic under, input logic straight);
      logic [CODE_W-1:0] clamped;
      clamped = over ? CODE_FULL : (under ? CODE_ZERO : raw);
      format_code = straight ? clamped : (clamped ^ CODE_MSB);
   endfunction

   logic [SYNC_W-1:0] sync_meta; // first stage, read only by sync_q
   logic [SYNC_W-1:0] sync_q; // settled pin levels
   logic start_prev; // previous settled start level
   conv_state_e state; // conversion sequence
   logic [PERIOD_W-1:0] since_start; // cycles since last start
   logic [GAP_W-1:0] gap_count; // long-gap detector
   logic start_pending; // start edge waiting for acquisition end
   logic [CODE_W-1:0] trial; // kept bits plus bit under test
   logic [BIT_IDX_W-1:0] bit_idx; // bit under test
   logic [STEP_W-1:0] step_cnt; // settling counter in a trial
   logic conv_stale; // this fastest-mode conversion follows a long gap
   logic result_stale; // stale flag of the shown result
   logic result_valid; // new result not yet read
   logic wr_pend; // write data phase pending
   logic [7:0] wr_addr; // address of pending write
   logic sw_start; // software start pulse

   wire start_fall = start_prev & ~sync_q[SY_START];
   wire acq_done = since_start >= period_for(sync_q[SY_FAST], sync_q[SY_PULSED]);
   wire start_now = (state == ST_ACQUIRE) & acq_done &
                    (start_pending | start_fall | ~sync_q[SY_START] | sw_start);
   wire trial_end = (state == ST_TRIAL) & (step_cnt == STEP_LAST);
   wire ahb_go = hsel & htrans[1] & hready;
   wire read_result = ahb_go & ~hwrite & (haddr == REG_RESULT);

   // pins from outside pass two flops before use
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         sync_meta <= SYNC_RST;
         sync_q <= SYNC_RST;
         start_prev <= 1'b1;
      end else begin
         sync_meta <= {under_range, over_range, comparator_high, pulsed_power_select,
                       fastest_rate_select, coding_select, convert_start_n};
         sync_q <= sync_meta;
         start_prev <= sync_q[SY_START];
      end
   end

   // a falling edge during acquisition waits for its end; edges while busy are dropped
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         start_pending <= 1'b0;
      end else if (start_now) begin
         start_pending <= 1'b0;
      end else if ((state == ST_ACQUIRE) & (start_fall | sw_start)) begin
         start_pending <= 1'b1;
      end
   end

   // start spacing sets the throughput ceiling of each mode
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         since_start <= PERIOD_SAT; // first start allowed at once
      end else if (start_now) begin
         since_start <= PERIOD_W'(1);
      end else if (since_start != PERIOD_SAT) begin
         since_start <= since_start + PERIOD_W'(1);
      end
   end

   // long gaps spoil the first fastest-mode result; flagged for the host
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         gap_count <= GAP_LIMIT; // power-up counts as a long gap
         conv_stale <= 1'b0;
      end else if (start_now) begin
         gap_count <= '0;
         conv_stale <= sync_q[SY_FAST] & (gap_count >= GAP_LIMIT);
      end else if (gap_count < GAP_LIMIT) begin
         gap_count <= gap_count + GAP_W'(1);
      end
   end

   // conversion sequence
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state <= ST_ACQUIRE;
      end else begin
         case (state)
            ST_ACQUIRE: begin
               if (start_now) begin
                  state <= ST_OPEN;
               end
            end
            ST_OPEN: begin
               state <= ST_CONNECT;
            end
            ST_CONNECT: begin
               state <= ST_TRIAL;
            end
            ST_TRIAL: begin
               if (trial_end && (bit_idx == LSB_IDX)) begin
                  state <= ST_FINISH;
               end
            end
            ST_FINISH: begin
               state <= ST_ACQUIRE;
            end
            default: begin
               state <= ST_ACQUIRE;
            end
         endcase
      end
   end

   // successive approximation, msb first
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         trial <= CODE_ZERO;
         bit_idx <= MSB_IDX;
         step_cnt <= '0;
      end else if (state == ST_CONNECT) begin
         trial <= trial_bit(MSB_IDX);
         bit_idx <= MSB_IDX;
         step_cnt <= '0;
      end else if (trial_end) begin
         step_cnt <= '0;
         if (bit_idx == LSB_IDX) begin
            trial <= sync_q[SY_COMP] ? trial : (trial & ~trial_bit(bit_idx));
         end else begin
            // keep or drop the tested bit, then try the next lower one
            trial <= (sync_q[SY_COMP] ? trial : (trial & ~trial_bit(bit_idx))) |
                     trial_bit(bit_idx - BIT_IDX_W'(1));
            bit_idx <= bit_idx - BIT_IDX_W'(1);
         end
      end else if (state == ST_TRIAL) begin
         step_cnt <= step_cnt + STEP_W'(1);
      end
   end

   // busy and result: code of this very conversion, no pipeline
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         busy <= 1'b0;
         result_code <= CODE_ZERO;
         result_stale <= 1'b0;
      end else if (start_now) begin
         busy <= 1'b1;
      end else if (state == ST_FINISH) begin
         busy <= 1'b0;
         result_code <= format_code(trial, sync_q[SY_OVER], sync_q[SY_UNDER], sync_q[SY_CODING]);
         result_stale <= conv_stale;
      end
   end

   // unread-result flag; a new result beats a read in the same cycle
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         result_valid <= 1'b0;
      end else if (state == ST_FINISH) begin
         result_valid <= 1'b1;
      end else if (read_result) begin
         result_valid <= 1'b0;
      end
   end

   // ahb address phase capture; zero wait states
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= ahb_go & hwrite;
         wr_addr <= haddr;
      end
   end

   // read data registered at the address phase; unmapped reads give zero
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         hrdata <= 32'h0000_0000;
      end else if (ahb_go && !hwrite) begin
         case (haddr)
            REG_STATUS: begin
               hrdata <= 32'((32'(busy) << STAT_BUSY_BIT) | (32'(result_stale) << STAT_STALE_BIT) |
                             (32'(result_valid) << STAT_VALID_BIT));
            end
            REG_RESULT: begin
               hrdata <= 32'(result_code);
            end
            default: begin
               hrdata <= 32'h0000_0000; // control reads zero too
            end
         endcase
      end
   end

   // software start is a write pulse, nothing is stored
   always_comb begin
      sw_start = wr_pend & (wr_addr == REG_CTRL) & hwdata[CTRL_START_BIT];
   end

   // bus answers: always ready, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // switch drive follows the state: ground switches open before the array leaves the inputs
   assign array_ground_switch = (state == ST_ACQUIRE);
   assign dummy_ground_switch = (state == ST_ACQUIRE);
   assign input_connect = (state == ST_ACQUIRE) | (state == ST_OPEN);
   assign reference_ground_connect = (state == ST_CONNECT) | (state == ST_TRIAL) | (state == ST_FINISH);
   assign array_switches = (state == ST_TRIAL) ? trial : CODE_ZERO;
   assign power_save = (state == ST_ACQUIRE) & sync_q[SY_PULSED] & ~sync_q[SY_FAST] & ~start_now;

   // checks next to the logic
   sequence s_open;
      (state == ST_OPEN) && !array_ground_switch && !dummy_ground_switch && input_connect;
   endsequence
   sequence s_connect;
      (state == ST_CONNECT) && !input_connect && reference_ground_connect;
   endsequence

   property p_start_after_acq;
      @(posedge core_clk) disable iff (!resetn)
      (state == ST_ACQUIRE) && acq_done && !sync_q[SY_START] |=> (state == ST_OPEN);
   endproperty
   a_start_after_acq: assert property (p_start_after_acq) else $error("no start at acquisition end");

   property p_switch_order;
      @(posedge core_clk) disable iff (!resetn)
      start_now |=> s_open ##1 s_connect;
   endproperty
   a_switch_order: assert property (p_switch_order) else $error("switch order wrong");

   property p_msb_first;
      @(posedge core_clk) disable iff (!resetn)
      $rose(state == ST_TRIAL) |-> (bit_idx == MSB_IDX) && (array_switches == CODE_MSB);
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("trial not msb first");

   property p_busy_drop;
      @(posedge core_clk) disable iff (!resetn)
      $rose(busy) |-> ##[1:CONV_BOUND] $fell(busy);
   endproperty
   a_busy_drop: assert property (p_busy_drop) else $error("busy never dropped");

   property p_same_conversion;
      @(posedge core_clk) disable iff (!resetn)
      (state == ST_FINISH) |=> !busy &&
         (result_code == format_code($past(trial), $past(sync_q[SY_OVER]), $past(sync_q[SY_UNDER]),
                                     $past(sync_q[SY_CODING])));
   endproperty
   a_same_conversion: assert property (p_same_conversion) else $error("result not of this conversion");

   property p_spacing;
      @(posedge core_clk) disable iff (!resetn)
      start_now |-> since_start >= period_for(sync_q[SY_FAST], sync_q[SY_PULSED]);
   endproperty
   a_spacing: assert property (p_spacing) else $error("starts closer than mode allows");

   property p_power_save;
      @(posedge core_clk) disable iff (!resetn)
      power_save |-> !busy && sync_q[SY_PULSED] && (state == ST_ACQUIRE);
   endproperty
   a_power_save: assert property (p_power_save) else $error("power save outside pulsed acquisition");

   property p_msb_flip;
      @(posedge core_clk) disable iff (!resetn)
      $fell(busy) && !$past(sync_q[SY_CODING]) |->
         ((result_code ^ CODE_MSB) == format_code($past(trial), $past(sync_q[SY_OVER]),
                                                   $past(sync_q[SY_UNDER]), 1'b1));
   endproperty
   a_msb_flip: assert property (p_msb_flip) else $error("twos complement not msb flip");

   property p_over_range;
      @(posedge core_clk) disable iff (!resetn)
      (state == ST_FINISH) && sync_q[SY_OVER] |=>
         (result_code == ($past(sync_q[SY_CODING]) ? CODE_FULL : (CODE_FULL ^ CODE_MSB)));
   endproperty
   a_over_range: assert property (p_over_range) else $error("over range code wrong");

   property p_edge_start;
      @(posedge core_clk) disable iff (!resetn)
      (state == ST_ACQUIRE) && start_fall |-> ##[0:START_BOUND] (state == ST_OPEN);
   endproperty
   a_edge_start: assert property (p_edge_start) else $error("falling edge did not start");

   property p_busy_hold;
      @(posedge core_clk) disable iff (!resetn)
      (state != ST_ACQUIRE) |-> busy;
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy low during conversion");

endmodule

/* File: hdl/sar_conversion_pkg.sv */
// constants, states and register map of the successive-approximation conversion control
package sar_conversion_pkg;

   // clock
   localparam int CLK_NS = 4; // core_clk period in ns

   // converter resolution
   localparam int CODE_W = 16;
   localparam int BIT_IDX_W = 4;
   localparam logic [BIT_IDX_W-1:0] MSB_IDX = 4'hf;
   localparam logic [BIT_IDX_W-1:0] LSB_IDX = 4'h0;

   // throughput limits per mode, in ksps
   localparam int FAST_KSPS = 570;
   localparam int NORMAL_KSPS = 500;
   localparam int PULSED_KSPS = 444;
   localparam int NS_PER_MS = 1000000; // also ns per ksps-sample count

   // least start-to-start spacing, rounded up to whole cycles
   localparam int PERIOD_W = 10;
   localparam logic [PERIOD_W-1:0] FAST_PERIOD =
      PERIOD_W'((NS_PER_MS + FAST_KSPS * CLK_NS - 1) / (FAST_KSPS * CLK_NS));
   localparam logic [PERIOD_W-1:0] NORMAL_PERIOD =
      PERIOD_W'((NS_PER_MS + NORMAL_KSPS * CLK_NS - 1) / (NORMAL_KSPS * CLK_NS));
   localparam logic [PERIOD_W-1:0] PULSED_PERIOD =
      PERIOD_W'((NS_PER_MS + PULSED_KSPS * CLK_NS - 1) / (PULSED_KSPS * CLK_NS));
   localparam logic [PERIOD_W-1:0] PERIOD_SAT = 10'h3ff;

   // fastest-mode accuracy gap
   localparam int GAP_MS = 1;
   localparam int GAP_CYCLES_DEF = (GAP_MS * NS_PER_MS) / CLK_NS;

   // output codes
   localparam logic [CODE_W-1:0] CODE_FULL = 16'hffff;
   localparam logic [CODE_W-1:0] CODE_ZERO = 16'h0000;
   localparam logic [CODE_W-1:0] CODE_MSB = 16'h8000;
   localparam logic [CODE_W-1:0] CODE_ONE = 16'h0001;

   // register byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_RESULT = 8'h08;

   // field positions
   localparam int CTRL_START_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_STALE_BIT = 1;
   localparam int STAT_VALID_BIT = 2;

   // synchroniser lanes and their reset level
   localparam int SYNC_W = 7;
   localparam int SY_START = 0;
   localparam int SY_CODING = 1;
   localparam int SY_FAST = 2;
   localparam int SY_PULSED = 3;
   localparam int SY_COMP = 4;
   localparam int SY_OVER = 5;
   localparam int SY_UNDER = 6;
   localparam logic [SYNC_W-1:0] SYNC_RST = 7'h03; // start idles high, binary coding

   // conversion sequence
   typedef enum logic [4:0] {
      ST_ACQUIRE = 5'b00001,
      ST_OPEN    = 5'b00010,
      ST_CONNECT = 5'b00100,
      ST_TRIAL   = 5'b01000,
      ST_FINISH  = 5'b10000
   } conv_state_e;

endpackage
